// file: verilog/cmd_pkg.sv
// Constants and types for the control-port command decoder.
package cmd_pkg;
  // ----------------------------------------------------------------
  // Command byte fields
  // ----------------------------------------------------------------
  localparam int DIR_BIT     = 7;
  localparam int TYPE_HI     = 6;
  localparam int TYPE_LO     = 5;
  localparam int MEM_SEL_BIT = 4;
  localparam logic [1:0] TYPE_LOCAL  = 2'h0;
  localparam logic [1:0] TYPE_GLOBAL = 2'h1;
  localparam logic [1:0] TYPE_BAD    = 2'h2;
  localparam logic [1:0] TYPE_MEMORY = 2'h3;
  // ----------------------------------------------------------------
  // Register and memory layout
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAN_EN_ADDR   = 5'h05;
  localparam logic [3:0] CHAN_EN_RESET  = 4'h0;
  localparam int         REG_COUNT      = 32;
  localparam int         WORDS_PER_BLK  = 8;
  localparam int         COEF_BLOCKS    = 5;
  localparam int         COEF_WORDS     = 40;
  localparam int         COEF_WIDTH     = 14;
  localparam int         CID_BLOCKS     = 4;
  localparam int         CID_WORDS      = 32;
  localparam logic [2:0] TOP_WORD       = 3'h7;
  // Identification byte; value is arbitrary.
  localparam logic [7:0] ID_BYTE_DEFAULT = 8'h5a;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_LOCAL, KIND_GLOBAL, KIND_COEF, KIND_CID} cmd_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_HOLD} cmd_state_t;
endpackage

// file: verilog/cmd_decoder.sv
// Command decoder for the four-channel codec control port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1: Enable register bits 3..0 select channels 4..1.
// RQ2: Writes go to every enabled channel together.
// RQ3: Host enables exactly one channel before reads.
// RQ4: Reads return identification byte before data.
// RQ5: Bit 7 direction, bits 4..0 address.
// RQ6: Bits 6..5 select local, global, memory.
// RQ7: Memory bit 4 low selects coefficient block.
// RQ8: Bit 4 high selects caller-ID block.
// RQ9: Host selects channels before local commands.
// RQ10: Low address bits give one to four bytes.
// RQ11: Chip select high abandons remaining registers.
// RQ12: Global commands ignore channels, same burst.
// RQ13: Per channel forty fourteen-bit coefficient words.
// RQ14: Coefficient blocks hold fixed filter roles.
// RQ15: Host enables channel before coefficient access.
// RQ16: Coefficient words two bytes, low bits dropped.
// RQ17: Coefficient burst walks eight words downward.
// RQ18: Chip select may end coefficient bursts.
// RQ19: Completed words survive; rest abandoned.
// RQ20: Shared caller-ID memory, four eight-word blocks.
// RQ21: Type value 10 is ignored entirely; the code still raises busy until chip select goes high.
module cmd_decoder
  import cmd_pkg::*;
#(
  parameter int         CHANNELS = 4,
  parameter logic [7:0] ID_BYTE  = ID_BYTE_DEFAULT
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Byte link from the port framer
  input  wire logic       csN,
  input  wire logic       rxValid,
  input  wire logic [7:0] rxByte,
  input  wire logic       txReq,
  output logic            txValid,
  output logic      [7:0] txByte,
  // Status
  output logic      [3:0] chanEnable,
  output logic            busy
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]            localRegs [CHANNELS][REG_COUNT];
  logic [7:0]            globalRegs [REG_COUNT];
  logic [COEF_WIDTH-1:0] coefMem [CHANNELS][COEF_WORDS];
  logic [15:0]           cidMem [CID_WORDS];

  cmd_state_t state_reg;
  cmd_kind_t  kind_reg;
  logic [4:0] regAddr_reg;
  logic [2:0] blk_reg;
  logic [2:0] word_reg;
  logic       lowPhase_reg;
  logic       idSent_reg;
  logic [7:0] hiByte_reg;
  logic [3:0] chanEn_reg;
  logic       txValid_reg;
  logic [7:0] txByte_reg;
  logic       busy_reg;

  // The read channel picker and the enable field are four bits wide.
  if (CHANNELS != 4)
    $error("cmd_decoder serves exactly four channels");

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] memIndex(input logic [2:0] blk, input logic [2:0] word);
    memIndex = {blk, word};
  endfunction

  function automatic logic [1:0] firstChannel(input logic [3:0] en);
    firstChannel = en[0] ? 2'h0 : en[1] ? 2'h1 : en[2] ? 2'h2 : en[3] ? 2'h3 : 2'h0;
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       cmdTake;
  logic [1:0] cmdType;
  logic       cmdLegal;
  cmd_kind_t  cmdKind;
  logic       byteStep;
  logic       isReg;
  logic       lastStep;
  logic [1:0] rdChan;

  assign cmdTake = state_reg == ST_IDLE && rxValid && !csN;
  assign cmdType = rxByte[TYPE_HI:TYPE_LO];                      // [RQ6]
  assign isReg   = kind_reg == KIND_LOCAL || kind_reg == KIND_GLOBAL;
  assign rdChan  = firstChannel(chanEn_reg);                     // [RQ3]

  always_comb
  begin
    cmdKind  = KIND_LOCAL;
    cmdLegal = 1'b1;
    case (cmdType)
      TYPE_LOCAL:  cmdKind = KIND_LOCAL;
      TYPE_GLOBAL: cmdKind = KIND_GLOBAL;
      TYPE_MEMORY:
      begin
        if (!rxByte[MEM_SEL_BIT])
        begin
          cmdKind  = KIND_COEF;                                  // [RQ7]
          cmdLegal = rxByte[3:0] < 4'(COEF_BLOCKS);
        end
        else
        begin
          cmdKind  = KIND_CID;                                   // [RQ8]
          cmdLegal = !rxByte[3] && rxByte[2:0] < 3'(CID_BLOCKS);
        end
      end
      default: cmdLegal = 1'b0;                                  // [RQ21]
    endcase
  end

  always_comb
  begin
    byteStep = 1'b0;
    if (!csN && state_reg == ST_WRITE)
      byteStep = rxValid;
    else if (!csN && state_reg == ST_READ)
      byteStep = txReq && idSent_reg;
  end

  assign lastStep = isReg ? regAddr_reg[1:0] == 2'h0 : lowPhase_reg && word_reg == 3'h0;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg    <= ST_IDLE;
      kind_reg     <= KIND_LOCAL;
      regAddr_reg  <= 5'h00;
      blk_reg      <= 3'h0;
      word_reg     <= 3'h0;
      lowPhase_reg <= 1'b0;
      idSent_reg   <= 1'b0;
      hiByte_reg   <= 8'h00;
    end
    else if (csN)
      state_reg <= ST_IDLE;                                      // [RQ11] [RQ18] [RQ19]
    else if (cmdTake)
    begin
      kind_reg     <= cmdKind;
      regAddr_reg  <= rxByte[4:0];                               // [RQ5]
      blk_reg      <= rxByte[2:0];
      word_reg     <= TOP_WORD;                                  // [RQ17] [RQ20]
      lowPhase_reg <= 1'b0;
      idSent_reg   <= 1'b0;
      if (!cmdLegal)
        state_reg <= ST_HOLD;                                    // [RQ21]
      else if (rxByte[DIR_BIT])
        state_reg <= ST_WRITE;                                   // [RQ5]
      else
        state_reg <= ST_READ;
    end
    else
    begin
      if (state_reg == ST_READ && txReq)
        idSent_reg <= 1'b1;                                      // [RQ4]
      if (byteStep)
      begin
        if (state_reg == ST_WRITE && !lowPhase_reg)
          hiByte_reg <= rxByte;                                  // [RQ16]
        if (lastStep)
          state_reg <= ST_HOLD;                                  // [RQ10]
        else if (isReg)
          regAddr_reg <= regAddr_reg - 5'h01;                    // [RQ10] [RQ12]
        else
        begin
          lowPhase_reg <= !lowPhase_reg;
          if (lowPhase_reg)
            word_reg <= word_reg - 3'h1;                         // [RQ17]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Busy flag, registered so the output leaves a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      busy_reg <= 1'b0;
    else if (csN)
      busy_reg <= 1'b0;                                          // [RQ11]
    else if (cmdTake)
      busy_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Channel enable register
  // ----------------------------------------------------------------
  logic wrStep;
  assign wrStep = byteStep && state_reg == ST_WRITE;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      chanEn_reg <= CHAN_EN_RESET;
    else if (wrStep && kind_reg == KIND_GLOBAL && regAddr_reg == CHAN_EN_ADDR)
      chanEn_reg <= rxByte[3:0];                                 // [RQ1]
  end

  // ----------------------------------------------------------------
  // Storage writes; a memory word lands only when both bytes arrived
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (wrStep)
    begin
      case (kind_reg)
        KIND_LOCAL:
          for (int ch = 0; ch < CHANNELS; ch++)
            if (chanEn_reg[ch])
              localRegs[ch][regAddr_reg] <= rxByte;              // [RQ2]
        KIND_GLOBAL:
          globalRegs[regAddr_reg] <= rxByte;                     // [RQ12]
        KIND_COEF:
          if (lowPhase_reg)
            for (int ch = 0; ch < CHANNELS; ch++)
              if (chanEn_reg[ch])
                coefMem[ch][memIndex(blk_reg, word_reg)] <= {hiByte_reg, rxByte[7:2]}; // [RQ13] [RQ14] [RQ16]
        default:
          if (lowPhase_reg)
            cidMem[5'(memIndex(blk_reg, word_reg))] <= {hiByte_reg, rxByte}; // [RQ20]
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0]            rdByte;
  logic [COEF_WIDTH-1:0] coefWord;
  logic [15:0]           cidWord;

  assign coefWord = coefMem[rdChan][memIndex(blk_reg, word_reg)];
  assign cidWord  = cidMem[5'(memIndex(blk_reg, word_reg))];

  always_comb
  begin
    case (kind_reg)
      KIND_LOCAL:  rdByte = localRegs[rdChan][regAddr_reg];
      KIND_GLOBAL: rdByte = regAddr_reg == CHAN_EN_ADDR ? {4'h0, chanEn_reg}
                                                        : globalRegs[regAddr_reg];
      KIND_COEF:   rdByte = lowPhase_reg ? {coefWord[5:0], 2'h0} : coefWord[13:6]; // [RQ16]
      default:     rdByte = lowPhase_reg ? cidWord[7:0] : cidWord[15:8];
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txValid_reg <= 1'b0;
      txByte_reg  <= 8'h00;
    end
    else
    begin
      txValid_reg <= !csN && state_reg == ST_READ && txReq;
      if (!csN && state_reg == ST_READ && txReq)
        txByte_reg <= idSent_reg ? rdByte : ID_BYTE;             // [RQ4]
    end
  end

  assign txValid    = txValid_reg;
  assign txByte     = txByte_reg;
  assign chanEnable = chanEn_reg;
  assign busy       = busy_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  id_first_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ4]
    state_reg == ST_READ && !idSent_reg && txReq && !csN |=> txValid && txByte == ID_BYTE)
    else $error("identification byte not sent first");

  cs_abort_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ11]
    csN |=> state_reg == ST_IDLE && !busy)
    else $error("chip select did not abandon burst");

  bad_type_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ21]
    cmdTake && rxByte[6:5] == TYPE_BAD |=> state_reg == ST_HOLD ##1 $stable(chanEn_reg))
    else $error("disallowed type was not ignored");

  burst_end_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ10]
    cmdTake && rxByte[7] && rxByte[6:5] == TYPE_GLOBAL && rxByte[1:0] == 2'h3
    ##2 (rxValid && !csN) ##2 (rxValid && !csN)
    ##2 (rxValid && !csN) ##2 (rxValid && !csN)
    |=> state_reg == ST_HOLD)
    else $error("register burst length wrong");

  coef_walk_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ17]
    wrStep && kind_reg == KIND_COEF && lowPhase_reg && word_reg != 3'h0
    |=> word_reg == $past(word_reg) - 3'h1 && !lowPhase_reg)
    else $error("coefficient word did not step down");

  mem_start_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ7]
    cmdTake && rxByte[6:5] == TYPE_MEMORY && !rxByte[4] && rxByte[3:0] < 4'h5
    |=> kind_reg == KIND_COEF && word_reg == TOP_WORD && !lowPhase_reg)
    else $error("coefficient burst start wrong");

  chan_en_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ1]
    wrStep && kind_reg == KIND_GLOBAL && regAddr_reg == CHAN_EN_ADDR
    |=> chanEnable == $past(rxByte[3:0]))
    else $error("channel enable not written");

  dir_bit_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
    cmdTake && cmdLegal |=> state_reg == ($past(rxByte[7]) ? ST_WRITE : ST_READ)
      && regAddr_reg == $past(rxByte[4:0]))
    else $error("direction or address decode wrong");

endmodule

`default_nettype wire

// file: dv/cmd_host.sv
// Host model that drives command bytes and read requests into the decoder.
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
  // Clock
  input  wire logic       clock,
  // Byte link toward the decoder
  output logic            csN,
  output logic            rxValid,
  output logic      [7:0] rxByte,
  output logic            txReq,
  input  wire logic       txValid,
  input  wire logic [7:0] txByte
);
  initial
  begin
    csN     = 1'b1;
    rxValid = 1'b0;
    rxByte  = 8'h00;
    txReq   = 1'b0;
  end
  // Sends one byte, then shows its inverse so no stale value lingers.
  task automatic put(input logic [7:0] b);
    rxValid = 1'b1;
    rxByte  = b;
    @(posedge clock);
    #1;
    rxValid = 1'b0;
    rxByte  = ~b;
    @(posedge clock);
    #1;
  endtask
  // Opens a command.
  task automatic start(input logic [7:0] cmd);
    csN = 1'b0;
    put(cmd);
  endtask
  // Requests one read byte and samples it in its single valid cycle.
  task automatic get(output logic [7:0] b, output logic v);
    txReq = 1'b1;
    @(posedge clock);
    #1;
    v     = txValid;
    b     = txByte;
    txReq = 1'b0;
    @(posedge clock);
    #1;
  endtask
  // Closes the command with a gap of chip select high.
  task automatic stop();
    csN = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking testbench for the control-port command decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cmd_pkg::*;
;
  logic          clock;
  logic          rst_b;
  wire logic       csN;
  wire logic       rxValid;
  wire logic [7:0] rxByte;
  wire logic       txReq;
  wire logic       txValid;
  wire logic [7:0] txByte;
  wire logic [3:0] chanEnable;
  wire logic       busy;
  int            miscompares = 0;
  int            comparisons = 0;
  int            cycles      = 0;
  localparam int LIMIT       = 20000;

  cmd_decoder i_dut (.clock(clock), .rst_b(rst_b), .csN(csN), .rxValid(rxValid),
    .rxByte(rxByte), .txReq(txReq), .txValid(txValid), .txByte(txByte),
    .chanEnable(chanEnable), .busy(busy));
  cmd_host i_host (.clock(clock), .csN(csN), .rxValid(rxValid), .rxByte(rxByte),
    .txReq(txReq), .txValid(txValid), .txByte(txByte));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic results();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic readByte(input logic [7:0] exp);
    logic [7:0] b;
    logic       v;
    i_host.get(b, v);
    checkBit(v, 1'b1);
    checkByte(b, exp);
  endtask
  function automatic logic [7:0] pat(input int k);
    return 8'h31 + 8'h11 * k[7:0];
  endfunction
  task automatic setEnable(input logic [3:0] e);
    i_host.start({1'b1, TYPE_GLOBAL, CHAN_EN_ADDR});
    i_host.put({4'h0, e});
    i_host.stop();
    checkByte({4'h0, chanEnable}, {4'h0, e});
  endtask

  task automatic testReset();
    checkBit(txValid, 1'b0);
    checkBit(busy, 1'b0);
    checkByte({4'h0, chanEnable}, 8'h00);
  endtask
  task automatic testGlobal();
    i_host.start(8'ha3);
    for (int k = 3; k >= 0; k--)
      i_host.put(8'h10 + k[7:0]);
    i_host.stop();
    i_host.start(8'h23);
    checkBit(busy, 1'b1);
    readByte(ID_BYTE_DEFAULT);
    for (int k = 3; k >= 0; k--)
      readByte(8'h10 + k[7:0]);
    i_host.stop();
    i_host.start(8'ha3);
    i_host.put(8'h23);
    i_host.put(8'h22);
    i_host.stop();
    checkBit(busy, 1'b0);
    i_host.start(8'h22);
    readByte(ID_BYTE_DEFAULT);
    readByte(8'h22);
    readByte(8'h11);
    readByte(8'h10);
    i_host.stop();
  endtask
  task automatic testBroadcast();
    for (int c = 0; c < 4; c++)
    begin
      setEnable(4'h1 << c);
      i_host.start(8'h80);
      i_host.put(c[7:0]);
      i_host.stop();
    end
    setEnable(4'h5);
    i_host.start(8'h80);
    i_host.put(8'h55);
    i_host.stop();
    for (int c = 0; c < 4; c++)
    begin
      setEnable(4'h1 << c);
      i_host.start(8'h00);
      readByte(ID_BYTE_DEFAULT);
      readByte(c[0] ? c[7:0] : 8'h55);
      i_host.stop();
    end
  endtask
  task automatic testBadType();
    setEnable(4'h3);
    i_host.start({1'b1, TYPE_BAD, CHAN_EN_ADDR});
    i_host.put(8'h0f);
    i_host.stop();
    checkByte({4'h0, chanEnable}, 8'h03);
  endtask
  task automatic testCoef();
    setEnable(4'h2);
    i_host.start(8'he4);
    for (int k = 0; k < 16; k++)
      i_host.put(pat(k));
    i_host.stop();
    i_host.start(8'he4);
    for (int k = 0; k < 3; k++)
      i_host.put(~pat(k));
    i_host.stop();
    i_host.start(8'h64);
    readByte(ID_BYTE_DEFAULT);
    for (int k = 0; k < 16; k++)
      readByte((k < 2 ? ~pat(k) : pat(k)) & (k[0] ? 8'hfc : 8'hff));
    i_host.stop();
  endtask
  task automatic testCallerId();
    i_host.start(8'hf3);
    for (int k = 0; k < 16; k++)
      i_host.put(~pat(k));
    i_host.stop();
    i_host.start(8'hfb);
    i_host.put(8'h00);
    i_host.put(8'h00);
    i_host.stop();
    i_host.start(8'h73);
    readByte(ID_BYTE_DEFAULT);
    for (int k = 0; k < 16; k++)
      readByte(~pat(k));
    i_host.stop();
  endtask

  initial
  begin
    rst_b = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    testReset();
    testGlobal();
    testBroadcast();
    testBadType();
    testCoef();
    testCallerId();
    results();
  end
endmodule
`default_nettype wire
